// ==== hdl/dssp_pkg.sv ====
// Constants of the dual synthesizer serial programming and lock block.
// Assumes one system clock; all pin inputs are asynchronous to it.
package dssp_pkg;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int DATA_W = 17;
  localparam int ADDR_W = 4;
  localparam int FRAME_W = DATA_W + ADDR_W;

  // ----------------------------------------
  // Latch addresses
  // ----------------------------------------
  localparam logic [3:0] ADDR_TEST = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_FIRST_MAIN = 4'h4;
  localparam logic [3:0] ADDR_SHARED_REF = 4'h5;
  localparam logic [3:0] ADDR_SECOND_MAIN = 4'h6;

  // ----------------------------------------
  // Control latch fields
  // ----------------------------------------
  localparam int FIRST_POWER_BIT = 0;
  localparam int SECOND_POWER_BIT = 1;
  localparam int FIRST_LOCK_REPORT_BIT = 2;
  localparam int SECOND_LOCK_REPORT_BIT = 3;
  localparam int FIRST_RANGE_BIT = 4;
  localparam int SECOND_RANGE_BIT = 5;
  localparam int DOUBLER_BIT = 6;

  // ----------------------------------------
  // Reset values, gains and relock count
  // ----------------------------------------
  localparam logic [16:0] LATCH_RESET = 17'h00000;
  localparam logic [4:0] PUMP_GAIN_HIGH = 5'h18;
  localparam logic [4:0] PUMP_GAIN_LOW = 5'h0C;
  localparam int RELOCK_CYCLES = 8;

endpackage

// ==== hdl/dssp_top.sv ====
// Serial programming front end, five addressed latches and lock monitor.
// Assumes serial pins, reference clock and phase comparators are asynchronous.
`timescale 1ns/10ps

// ----------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------
module dssp_sync
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic level_q;
  logic level_d;
  logic rise_q;
  logic rise_d;

  always_comb
  begin
    stage_d = {stage_q[1:0], pin};
    level_d = level_q;
    rise_d = 1'b0;
    // Only the second and third stages are compared
    if (stage_q[1] == stage_q[2] && stage_q[2] != level_q)
    begin
      level_d = stage_q[2];
      rise_d = stage_q[2];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_q <= 3'h0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end
    else
    begin
      stage_q <= stage_d;
      level_q <= level_d;
      rise_q <= rise_d;
    end
  end

  assign level = level_q;
  assign rise = rise_q;
endmodule

module dssp_top
  import dssp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic serial_latch_strobe,
  input wire logic ref_clk,
  input wire logic first_phase_err_high,
  input wire logic second_phase_err_high,
  output logic [16:0] test_latch,
  output logic [16:0] control_latch,
  output logic [16:0] first_main_divider,
  output logic [16:0] shared_reference_divider,
  output logic [16:0] second_main_divider,
  output logic first_synth_power_on,
  output logic second_synth_power_on,
  output logic [4:0] first_pump_current,
  output logic [4:0] second_pump_current,
  output logic doubler_enable,
  output logic lock_lost_flag
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic data_lvl;
  logic sclk_rise;
  logic strobe_rise;
  logic ref_rise;
  logic [1:0] err_lvl;

  dssp_sync u_data (.clock(clock), .rst_n(rst_n), .pin(ser_data), .level(data_lvl), .rise());
  dssp_sync u_sclk (.clock(clock), .rst_n(rst_n), .pin(ser_clk), .level(), .rise(sclk_rise));
  dssp_sync u_strb (.clock(clock), .rst_n(rst_n), .pin(serial_latch_strobe), .level(),
                    .rise(strobe_rise));
  dssp_sync u_ref (.clock(clock), .rst_n(rst_n), .pin(ref_clk), .level(), .rise(ref_rise));
  dssp_sync u_erra (.clock(clock), .rst_n(rst_n), .pin(first_phase_err_high),
                    .level(err_lvl[0]), .rise());
  dssp_sync u_errb (.clock(clock), .rst_n(rst_n), .pin(second_phase_err_high),
                    .level(err_lvl[1]), .rise());

  // ----------------------------------------
  // Shift register and latches
  // ----------------------------------------
  logic [FRAME_W-1:0] shift_q;
  logic [FRAME_W-1:0] shift_d;
  logic [16:0] test_q, test_d, ctrl_q, ctrl_d;
  logic [16:0] maina_q, maina_d, refd_q, refd_d, mainb_q, mainb_d;
  logic [4:0] gaina_q, gaina_d, gainb_q, gainb_d;
  logic [ADDR_W-1:0] frame_addr;
  logic [DATA_W-1:0] frame_data;

  // Address sits in the low bits because it enters last
  assign frame_addr = shift_q[ADDR_W-1:0];
  assign frame_data = shift_q[FRAME_W-1:ADDR_W];

  always_comb
  begin
    shift_d = shift_q;
    test_d = test_q;
    ctrl_d = ctrl_q;
    maina_d = maina_q;
    refd_d = refd_q;
    mainb_d = mainb_q;
    if (sclk_rise)
    begin
      shift_d = {shift_q[FRAME_W-2:0], data_lvl};
    end
    // No frame validity check: whatever is shifted gets loaded unless its address is unmapped
    if (strobe_rise)
    begin
      case (frame_addr)
        ADDR_TEST: test_d = frame_data;
        ADDR_CONTROL: ctrl_d = frame_data;
        ADDR_FIRST_MAIN: maina_d = frame_data;
        ADDR_SHARED_REF: refd_d = frame_data;
        ADDR_SECOND_MAIN: mainb_d = frame_data;
        default: test_d = test_q;
      endcase
    end
    gaina_d = ctrl_d[FIRST_RANGE_BIT] ? PUMP_GAIN_HIGH : PUMP_GAIN_LOW;
    gainb_d = ctrl_d[SECOND_RANGE_BIT] ? PUMP_GAIN_HIGH : PUMP_GAIN_LOW;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q <= '0;
      test_q <= LATCH_RESET;
      ctrl_q <= LATCH_RESET;
      maina_q <= LATCH_RESET;
      refd_q <= LATCH_RESET;
      mainb_q <= LATCH_RESET;
      gaina_q <= PUMP_GAIN_LOW;
      gainb_q <= PUMP_GAIN_LOW;
    end
    else
    begin
      shift_q <= shift_d;
      test_q <= test_d;
      ctrl_q <= ctrl_d;
      maina_q <= maina_d;
      refd_q <= refd_d;
      mainb_q <= mainb_d;
      gaina_q <= gaina_d;
      gainb_q <= gainb_d;
    end
  end

  // ----------------------------------------
  // Lock monitor, one qualifier per synthesizer
  // ----------------------------------------
  logic [1:0] locked_q, locked_d;
  logic [3:0] cnt_q [2];
  logic [3:0] cnt_d [2];
  logic [1:0] report_en;
  logic lock_flag_q, lock_flag_d;

  assign report_en = {ctrl_q[SECOND_LOCK_REPORT_BIT], ctrl_q[FIRST_LOCK_REPORT_BIT]};

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      locked_d[i] = locked_q[i];
      cnt_d[i] = cnt_q[i];
      if (err_lvl[i])
      begin
        locked_d[i] = 1'b0;
        cnt_d[i] = 4'h0;
      end
      else if (ref_rise && !locked_q[i])
      begin
        if (cnt_q[i] == 4'(RELOCK_CYCLES - 1))
        begin
          locked_d[i] = 1'b1;
          cnt_d[i] = 4'h0;
        end
        else
        begin
          cnt_d[i] = cnt_q[i] + 4'h1;
        end
      end
    end
    // Disabled loops never pull the flag low; error is taken from the sync output
    lock_flag_d = &(locked_d | ~report_en);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      locked_q <= 2'h0;
      cnt_q[0] <= 4'h0;
      cnt_q[1] <= 4'h0;
      lock_flag_q <= 1'b1;
    end
    else
    begin
      locked_q <= locked_d;
      cnt_q[0] <= cnt_d[0];
      cnt_q[1] <= cnt_d[1];
      lock_flag_q <= lock_flag_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign test_latch = test_q;
  assign control_latch = ctrl_q;
  assign first_main_divider = maina_q;
  assign shared_reference_divider = refd_q;
  assign second_main_divider = mainb_q;
  assign first_synth_power_on = ctrl_q[FIRST_POWER_BIT];
  assign second_synth_power_on = ctrl_q[SECOND_POWER_BIT];
  assign first_pump_current = gaina_q;
  assign second_pump_current = gainb_q;
  assign doubler_enable = ctrl_q[DOUBLER_BIT];
  assign lock_lost_flag = lock_flag_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  shift_order_a: assert property (sclk_rise |=> shift_q[0] == $past(data_lvl))
    else $error("serial bit not shifted in at the low end");
  ctrl_load_a: assert property (strobe_rise && frame_addr == ADDR_CONTROL
    |=> ctrl_q == $past(frame_data)) else $error("control latch not loaded");
  maina_load_a: assert property (strobe_rise && frame_addr == ADDR_FIRST_MAIN
    |=> maina_q == $past(frame_data)) else $error("first divider not loaded");
  hold_a: assert property (!strobe_rise |=> $stable(refd_q) && $stable(test_q))
    else $error("latch changed without strobe");
  gain_a: assert property (strobe_rise && frame_addr == ADDR_CONTROL
    |=> first_pump_current ==
    ($past(frame_data[FIRST_RANGE_BIT]) ? PUMP_GAIN_HIGH : PUMP_GAIN_LOW))
    else $error("first pump current mismatch");
  power_a: assert property (strobe_rise && frame_addr == ADDR_CONTROL
    |=> second_synth_power_on == $past(frame_data[SECOND_POWER_BIT]))
    else $error("power bit not applied");
  drop_a: assert property (err_lvl[0] && report_en[0] |=> !lock_lost_flag)
    else $error("lock flag did not drop on error");
  relock_a: assert property (!locked_q[0] && cnt_q[0] != 4'(RELOCK_CYCLES - 1)
    |=> !locked_q[0]) else $error("relocked before eight cycles");
  restart_a: assert property (err_lvl[1] |=> cnt_q[1] == 4'h0 && !locked_q[1])
    else $error("relock count not restarted");

  relock_c: cover property (!locked_q[0] ##1 locked_q[0]);
  frame_c: cover property (strobe_rise && frame_addr == ADDR_SECOND_MAIN);
  flag_c: cover property (!lock_lost_flag ##1 lock_lost_flag);

endmodule

// ==== bench/dssp_host_model.sv ====
// Host model that shifts framed words into the serial pins.
// Assumes the bench clock; pins change on its falling edge.
`timescale 1ns/10ps
module dssp_host_model
  import dssp_pkg::*;
(
  input wire logic clock,
  output logic ser_data,
  output logic ser_clk,
  output logic serial_latch_strobe
);
  initial
  begin
    ser_data = 1'b0;
    ser_clk = 1'b0;
    serial_latch_strobe = 1'b0;
  end

  // ----------------------------------------
  // One frame, then the strobe
  // ----------------------------------------
  task automatic send(input logic [3:0] addr, input logic [16:0] data);
    logic [FRAME_W-1:0] frame;
    frame = {data, addr};
    @(negedge clock);
    // Data moves with the falling shift clock, so the link period is 8 clocks
    for (int i = FRAME_W - 1; i >= 0; i--)
    begin
      ser_data = frame[i];
      repeat (4) @(negedge clock);
      ser_clk = 1'b1;
      repeat (4) @(negedge clock);
      ser_clk = 1'b0;
    end
    repeat (2) @(negedge clock);
    // Stale bit inverted so a released line never looks valid
    ser_data = ~frame[0];
    serial_latch_strobe = 1'b1;
    repeat (4) @(negedge clock);
    serial_latch_strobe = 1'b0;
    repeat (6) @(negedge clock);
  endtask
endmodule

// ==== bench/tb_dssp_top.sv ====
// Bench for the serial programming front end and lock monitor.
// Assumes the host model owns the serial pins; the bench drives the rest.
`timescale 1ns/10ps
module tb_dssp_top
  import dssp_pkg::*;
  ;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ser_data, ser_clk, serial_latch_strobe;
  logic ref_clk = 1'b0;
  logic first_phase_err_high = 1'b0;
  logic second_phase_err_high = 1'b0;
  logic [16:0] test_latch, control_latch, first_main_divider;
  logic [16:0] shared_reference_divider, second_main_divider;
  logic first_synth_power_on, second_synth_power_on, doubler_enable;
  logic [4:0] first_pump_current, second_pump_current;
  logic lock_lost_flag;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  dssp_host_model i_host (.clock, .ser_data, .ser_clk, .serial_latch_strobe);
  dssp_top i_dut (.clock, .rst_n, .ser_data, .ser_clk, .serial_latch_strobe,
    .ref_clk, .first_phase_err_high, .second_phase_err_high, .test_latch,
    .control_latch, .first_main_divider, .shared_reference_divider,
    .second_main_divider, .first_synth_power_on, .second_synth_power_on,
    .first_pump_current, .second_pump_current, .doubler_enable, .lock_lost_flag);

  initial
  begin
    forever #10 clock = ~clock;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic ref_run(input int n);
    repeat (n)
    begin
      repeat (4) @(negedge clock);
      ref_clk = 1'b1;
      repeat (4) @(negedge clock);
      ref_clk = 1'b0;
    end
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      errors++;
      results();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(control_latch, LATCH_RESET);
    chk(17'(first_pump_current), 17'h0000C);
    chk(17'(lock_lost_flag), 17'h00001);
    i_host.send(ADDR_TEST, 17'h00000);
    chk(test_latch, 17'h00000);
    $display("test reset done");
  endtask

  task automatic t_control();
    i_host.send(ADDR_CONTROL, 17'h0001F);
    chk(17'(first_synth_power_on), 17'h00001);
    chk(17'(second_synth_power_on), 17'h00001);
    chk(17'(first_pump_current), 17'h00018);
    chk(17'(second_pump_current), 17'h0000C);
    chk(17'(doubler_enable), 17'h00000);
    // Both reports on while neither loop has qualified yet
    chk(17'(lock_lost_flag), 17'h00000);
    i_host.send(ADDR_CONTROL, 17'h10060);
    chk(control_latch, 17'h10060);
    chk(17'(first_synth_power_on), 17'h00000);
    chk(17'(first_pump_current), 17'h0000C);
    chk(17'(second_pump_current), 17'h00018);
    chk(17'(doubler_enable), 17'h00001);
    $display("test control done");
  endtask

  task automatic t_latch();
    i_host.send(ADDR_FIRST_MAIN, 17'h1ABCD);
    i_host.send(ADDR_SHARED_REF, 17'h00A00);
    i_host.send(ADDR_SECOND_MAIN, 17'h0B5A5);
    i_host.send(4'h2, 17'h1FFFF);
    chk(first_main_divider, 17'h1ABCD);
    chk(shared_reference_divider, 17'h00A00);
    chk(second_main_divider, 17'h0B5A5);
    chk(control_latch, 17'h10060);
    chk(test_latch, 17'h00000);
    $display("test latches done");
  endtask

  task automatic t_lock();
    i_host.send(ADDR_CONTROL, 17'h00004);
    ref_run(8);
    repeat (6) @(negedge clock);
    chk(17'(lock_lost_flag), 17'h00001);
    second_phase_err_high = 1'b1;
    repeat (10) @(negedge clock);
    chk(17'(lock_lost_flag), 17'h00001);
    second_phase_err_high = 1'b0;
    first_phase_err_high = 1'b1;
    repeat (6) @(negedge clock);
    chk(17'(lock_lost_flag), 17'h00000);
    first_phase_err_high = 1'b0;
    ref_run(7);
    chk(17'(lock_lost_flag), 17'h00000);
    first_phase_err_high = 1'b1;
    repeat (6) @(negedge clock);
    first_phase_err_high = 1'b0;
    ref_run(7);
    chk(17'(lock_lost_flag), 17'h00000);
    ref_run(1);
    repeat (6) @(negedge clock);
    chk(17'(lock_lost_flag), 17'h00001);
    $display("test lock done");
  endtask

  initial
  begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    t_reset();
    t_control();
    t_latch();
    t_lock();
    results();
  end
endmodule
